/* File: window_watchdog_reset_gen.sv */
// Power-on reset generator with window watchdog and system enable
`timescale 1ns/1ps
module window_watchdog_reset_gen
	import wdt_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Supply monitor
	input wire logic supply_low_i,
	// Host side
	input wire logic kick_input_i,
	output logic host_reset_n_o,
	output logic sys_enable_out_o
);

	typedef struct packed {
		wd_state_type state;
		logic [6:0] div;
		logic [6:0] cnt;
		logic [11:0] filt;
		logic [1:0] sync;
		logic rst_n;
		logic sys_enable_out;
	} wd_type;

	localparam wd_type WD_RESET = '{
		state: STATE_RESET,
		div: DIV_RESET,
		cnt: CNT_RESET,
		filt: FILT_RESET,
		sync: 2'h0,
		rst_n: 1'b0,
		sys_enable_out: 1'b0
	};

	wd_type st;
	wd_type next_st;
	logic tick;
	logic trig;
	logic low;
	logic dip_expired;

	////////////////////////////////////////////////////////////////////////////
	// Tick and filter decodes
	assign tick = (st.div == TICK_LAST);
	assign low = st.sync[1];
	assign dip_expired = low && (st.filt == REACT_LAST);

	// Trigger sampler, idle while the host is held in reset
	kick_sampler sampler (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.tick_i(tick),
		.clear_i(!st.rst_n),
		.kick_input_i(kick_input_i),
		.trig_o(trig)
	);

	////////////////////////////////////////////////////////////////////////////
	// Sequencer next state
	always_comb begin
		next_st = st;

		// Divide by one hundred
		next_st.div = tick ? DIV_RESET : 7'(st.div + 7'h01);

		// Two-stage synchroniser
		next_st.sync = {st.sync[0], supply_low_i};

		// Dip length counter, cleared by any good sample
		if (!low) begin
			next_st.filt = FILT_RESET;
		end else if (st.filt != REACT_LAST) begin
			next_st.filt = 12'(st.filt + 12'h001);
		end

		unique case (st.state)
			ST_PWRDN: begin
				if (!low) begin
					next_st.state = ST_PWRUP;
					next_st.cnt = CNT_RESET;
					next_st.div = DIV_RESET;
				end
			end
			ST_PWRUP: begin
				if (tick) begin
					next_st.cnt = 7'(st.cnt + 7'h01);
					if (st.cnt == 7'(PWRUP_TICKS - 7'h01)) begin
						next_st.state = ST_CLOSED;
						next_st.cnt = CNT_RESET;
					end
				end
			end
			ST_CLOSED: begin
				if (trig) begin
					next_st.state = ST_FAULT;
					next_st.sys_enable_out = 1'b0;
				end else if (tick) begin
					next_st.cnt = 7'(st.cnt + 7'h01);
					if (st.cnt == 7'(CLOSED_WINDOW_TIME - 7'h01)) begin
						next_st.state = ST_OPEN;
					end
				end
			end
			ST_OPEN: begin
				if (trig) begin
					// Late fourth sample lands here too
					next_st.state = ST_CLOSED;
					next_st.cnt = CNT_RESET;
					next_st.sys_enable_out = 1'b1;
				end else if (tick) begin
					next_st.cnt = 7'(st.cnt + 7'h01);
					if (st.cnt == 7'(WINDOW_END - 7'h01)) begin
						next_st.state = ST_WDRST;
						next_st.cnt = CNT_RESET;
						next_st.sys_enable_out = 1'b0;
					end
				end
			end
			ST_FAULT: begin
				if (tick) begin
					next_st.cnt = 7'(st.cnt + 7'h01);
					if (st.cnt == 7'(RESET_START_DELAY - 7'h01)) begin
						next_st.state = ST_WDRST;
						next_st.cnt = CNT_RESET;
					end
				end
			end
			ST_WDRST: begin
				if (tick) begin
					next_st.cnt = 7'(st.cnt + 7'h01);
					if (st.cnt == 7'(WATCHDOG_RESET_LENGTH - 7'h01)) begin
						next_st.state = ST_CLOSED;
						next_st.cnt = CNT_RESET;
					end
				end
			end
			default: begin
				next_st.state = ST_PWRDN;
				next_st.cnt = CNT_RESET;
			end
		endcase

		// Long undervoltage overrides everything
		if (dip_expired && st.state != ST_PWRDN) begin
			next_st.state = ST_PWRDN;
			next_st.cnt = CNT_RESET;
			next_st.sys_enable_out = 1'b0;
		end

		// Host reset output follows the sequencer state
		next_st.rst_n = (next_st.state == ST_CLOSED) || (next_st.state == ST_OPEN)
			|| (next_st.state == ST_FAULT);
		if (!next_st.rst_n) begin
			next_st.sys_enable_out = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st <= WD_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Outputs come straight from flip-flops
	assign host_reset_n_o = st.rst_n;
	assign sys_enable_out_o = st.sys_enable_out;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_tick_spacing: assert property (@(posedge clk_i) disable iff (!nrst_i)
		tick |=> !tick [*8])
		else $error("ticks closer than the divider allows");

	chk_dip_length: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(st.state != ST_PWRDN) ##1 (st.state == ST_PWRDN) |-> $past(st.filt) == REACT_LAST)
		else $error("power-down entered before the reaction time");

	chk_pwrup_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(st.state == ST_PWRUP || st.state == ST_PWRDN) |-> !host_reset_n_o)
		else $error("host reset released during power sequence");

	chk_release_window: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$rose(host_reset_n_o) |-> st.state == ST_CLOSED && st.cnt == CNT_RESET)
		else $error("reset release did not start a closed window");

	chk_pretrigger_fault: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(st.state == ST_CLOSED && trig && !dip_expired) |=> st.state == ST_FAULT
			&& !sys_enable_out_o)
		else $error("pretrigger not flagged");

	chk_open_kick: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(st.state == ST_OPEN && trig && !dip_expired) |=> st.state == ST_CLOSED
			&& st.cnt == CNT_RESET && sys_enable_out_o)
		else $error("open-window trigger did not restart window");

	chk_reset_start: assert property (@(posedge clk_i) disable iff (!nrst_i)
		((st.state == ST_OPEN || st.state == ST_FAULT) && tick && !trig && !dip_expired
			&& st.cnt == 7'(RESET_START_DELAY - 7'h01)) |=> !host_reset_n_o)
		else $error("watchdog reset not started at 64 ticks");

	chk_enable_reset: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!host_reset_n_o |-> !sys_enable_out_o)
		else $error("system enable high while host in reset");

	// Main scenarios
	cov_good_kick: cover property (@(posedge clk_i) disable iff (!nrst_i)
		st.state == ST_OPEN && trig);
	cov_pretrigger: cover property (@(posedge clk_i) disable iff (!nrst_i)
		st.state == ST_CLOSED && trig);
	cov_missing_kick: cover property (@(posedge clk_i) disable iff (!nrst_i)
		st.state == ST_OPEN ##1 st.state == ST_WDRST);
	cov_power_down: cover property (@(posedge clk_i) disable iff (!nrst_i)
		dip_expired && host_reset_n_o);

endmodule : window_watchdog_reset_gen

/* File: wdt_pkg.sv */
// Constants and types shared by the window watchdog and reset generator
package wdt_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Time base: clk_i is the oscillator
	localparam int TICK_DIV = 100;
	localparam logic [6:0] TICK_LAST = 7'(TICK_DIV - 1);
	localparam logic [6:0] DIV_RESET = 7'h00;

	// Reaction time in microseconds and its cycle count
	localparam int CLK_KHZ = 40000;
	localparam int DIP_REACTION_TIME_US = 100;
	localparam int REACT_CYCLES = DIP_REACTION_TIME_US * CLK_KHZ / 1000;
	localparam logic [11:0] REACT_LAST = 12'(REACT_CYCLES - 1);
	localparam logic [11:0] FILT_RESET = 12'h000;

	// Durations in cycle ticks
	localparam logic [6:0] PWRUP_TICKS = 7'h40;
	localparam logic [6:0] CLOSED_WINDOW_TIME = 7'h20;
	localparam logic [6:0] OPEN_WINDOW_TIME = 7'h20;
	localparam logic [6:0] RESET_START_DELAY = 7'h40;
	localparam logic [6:0] WATCHDOG_RESET_LENGTH = 7'h40;
	localparam logic [6:0] WINDOW_END = 7'(CLOSED_WINDOW_TIME + OPEN_WINDOW_TIME);
	localparam logic [6:0] CNT_RESET = 7'h00;

	// Host kick interval in tenths of a tick, for reference only
	localparam int KICK_INTERVAL_TENTHS = 464;

	// Trigger pattern, oldest sample in the top bit
	localparam logic [3:0] KICK_PATTERN = 4'hc;
	localparam logic [2:0] HIST_RESET = 3'h0;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer states
	typedef enum logic [2:0] {
		ST_PWRDN = 3'b000,
		ST_PWRUP = 3'b001,
		ST_CLOSED = 3'b010,
		ST_OPEN = 3'b011,
		ST_FAULT = 3'b100,
		ST_WDRST = 3'b101
	} wd_state_type;

	localparam wd_state_type STATE_RESET = ST_PWRUP;

endpackage : wdt_pkg

/* File: kick_sampler.sv */
// Per-tick sampler and falling-edge decoder for the kick input
`timescale 1ns/1ps
module kick_sampler
	import wdt_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Control
	input wire logic tick_i,
	input wire logic clear_i,
	// Kick pin and decoded trigger
	input wire logic kick_input_i,
	output logic trig_o
);

	typedef struct packed {
		logic [2:0] hist;
		logic trig;
	} samp_type;

	samp_type st;
	samp_type next_st;

	////////////////////////////////////////////////////////////////////////////
	// Shift one sample per tick, decode high-high-low-low
	always_comb begin
		next_st = st;
		next_st.trig = 1'b0;
		if (clear_i) begin
			next_st.hist = HIST_RESET;
		end else if (tick_i) begin
			next_st.hist = {st.hist[1:0], kick_input_i};
			next_st.trig = ({st.hist, kick_input_i} == KICK_PATTERN);
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st <= '{hist: HIST_RESET, trig: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign trig_o = st.trig;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_trig_after_tick: assert property (@(posedge clk_i) disable iff (!nrst_i)
		trig_o |-> $past(tick_i) && !$past(kick_input_i))
		else $error("trigger without a low sample on the previous tick");

	chk_clear_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
		clear_i |=> !trig_o)
		else $error("trigger decoded while sampler cleared");

endmodule : kick_sampler

/* File: host_model.sv */
// Host microcontroller model that kicks the watchdog at a set interval
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic clk_i,
	// Device side
	input wire logic host_reset_n_i,
	// Test control
	input wire logic en_i,
	input wire logic [15:0] interval_i,
	// Kick pin
	output logic kick_o
);
	logic [15:0] cnt;

	////////////////////////////////////////////////////////////////////////////
	// Falling edge every interval, low for four ticks, idle while in reset
	always_ff @(posedge clk_i) begin
		if (!host_reset_n_i || !en_i) begin
			cnt <= 16'h0000;
			kick_o <= 1'b1;
		end else begin
			cnt <= (cnt == interval_i) ? 16'h0000 : cnt + 16'h0001;
			if (cnt == interval_i)
				kick_o <= 1'b0;
			else if (cnt == 16'h0190)
				kick_o <= 1'b1;
		end
	end
endmodule : host_model

/* File: testbench.sv */
// Self-checking testbench for the window watchdog and reset generator
`timescale 1ns/1ps
module testbench
	import wdt_pkg::*;
;
	logic clk_i, nrst_i, supply_low_i, kick_input_i, en;
	logic host_reset_n_o, sys_enable_out_o;
	logic [15:0] interval;
	int fails, num_checks, n, bad;
	localparam int PWR = int'(PWRUP_TICKS) * TICK_DIV;
	localparam int WDL = int'(WATCHDOG_RESET_LENGTH) * TICK_DIV;
	localparam int RSD = int'(RESET_START_DELAY) * TICK_DIV;

	////////////////////////////////////////////////////////////////////////////
	// Device and host
	window_watchdog_reset_gen window_watchdog_reset_gen_inst (.clk_i, .nrst_i, .supply_low_i,
		.kick_input_i, .host_reset_n_o, .sys_enable_out_o);
	host_model host_model_inst (.clk_i, .host_reset_n_i(host_reset_n_o), .en_i(en),
		.interval_i(interval), .kick_o(kick_input_i));

	// Clock and hang guard
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		#2400000;
		fails++;
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////////
	// Helpers
	task step();
		@(posedge clk_i);
		#2;
	endtask : step
	task check_bit(string name, logic exp, logic got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %b seen %b", name, exp, got);
		end
	endtask : check_bit
	task check_cnt(string name, int lo, int hi, int got);
		num_checks++;
		if (got < lo || got > hi) begin
			fails++;
			$display("unexpected %s: expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask : check_cnt
	task wait_sig(bit sel, logic lvl, int max, output int cnt);
		cnt = 0;
		while ((sel ? sys_enable_out_o : host_reset_n_o) !== lvl && cnt < max) begin
			step();
			cnt++;
		end
	endtask : wait_sig
	task stop_test();
		if (fails == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_powerup();
		wait_sig(0, 1'b1, 8000, n);
		check_cnt("power-up delay", PWR - 3, PWR + 3, n);
		check_bit("enable in power-up", 1'b0, sys_enable_out_o);
	endtask : t_powerup
	task t_late_edge();
		wait_sig(1, 1'b1, 3400, n);
		check_cnt("late kick enable", 3150, 3260, n);
		en = 1'b0;
	endtask : t_late_edge
	task t_train();
		interval = 16'h1220;
		en = 1'b1;
		bad = 0;
		repeat (16000) begin
			step();
			if (host_reset_n_o !== 1'b1 || sys_enable_out_o !== 1'b1)
				bad++;
		end
		check_cnt("kick train faults", 0, 0, bad);
	endtask : t_train
	task t_missing();
		en = 1'b0;
		wait_sig(1, 1'b0, 7000, n);
		check_cnt("missing kick drop", 1, RSD, n);
		check_bit("reset on missing kick", 1'b0, host_reset_n_o);
		interval = 16'h07d0;
		en = 1'b1;
		wait_sig(0, 1'b1, 7000, n);
		check_cnt("watchdog reset length", WDL - 100, WDL + 3, n);
	endtask : t_missing
	task t_pretrigger();
		wait_sig(0, 1'b0, 7000, n);
		check_cnt("pretrigger reset start", RSD - 100, RSD + 3, n);
		check_bit("enable after pretrigger", 1'b0, sys_enable_out_o);
		en = 1'b0;
		wait_sig(0, 1'b1, 7000, n);
		check_cnt("pretrigger reset length", WDL - 100, WDL + 3, n);
	endtask : t_pretrigger
	task t_supply();
		supply_low_i = 1'b1;
		wait_sig(0, 1'b0, 4100, n);
		check_cnt("dip reaction", REACT_CYCLES - 2, REACT_CYCLES + 5, n);
		repeat (1000) step();
		check_bit("enable in power-down", 1'b0, sys_enable_out_o);
		supply_low_i = 1'b0;
		wait_sig(0, 1'b1, 7000, n);
		check_cnt("recovery delay", PWR - 2, PWR + 5, n);
		// Dip shorter than the reaction time, then watch a while longer
		supply_low_i = 1'b1;
		bad = 0;
		repeat (3000) begin
			step();
			if (step_low())
				bad++;
		end
		supply_low_i = 1'b0;
		repeat (1500) begin
			step();
			if (step_low())
				bad++;
		end
		check_cnt("short dip faults", 0, 0, bad);
	endtask : t_supply
	function automatic bit step_low();
		return host_reset_n_o !== 1'b1;
	endfunction : step_low

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		nrst_i = 1'b0;
		supply_low_i = 1'b0;
		en = 1'b1;
		interval = 16'h0bea;
		fails = 0;
		num_checks = 0;
		repeat (3) @(posedge clk_i);
		#2 nrst_i = 1'b1;
		t_powerup();
		t_late_edge();
		t_train();
		t_missing();
		t_pretrigger();
		t_supply_run();
		stop_test();
	end
	task t_supply_run();
		t_supply();
	endtask : t_supply_run
endmodule : testbench
